// File: src/ucd_regs.svh
// offsets, field positions, codes and timing counts for the channel command decoder
// assumes a 32-bit avalon-mm slave with byte addresses, one word per register
`ifndef UCD_REGS_SVH
`define UCD_REGS_SVH
`define UCD_OFS_CMD_A      4'h0
`define UCD_OFS_CMD_B      4'h4
`define UCD_OFS_STATUS     4'h8
`define UCD_OFS_EVENT      4'hC
`define UCD_CODE_MSB       7
`define UCD_CODE_LSB       4
`define UCD_BIT_TX_DIS     3
`define UCD_BIT_TX_EN      2
`define UCD_BIT_RX_DIS     1
`define UCD_BIT_RX_EN      0
`define UCD_CMD_START_BRK  4'h6
`define UCD_CMD_STOP_BRK   4'h7
`define UCD_CMD_RTS_ON     4'h8
`define UCD_CMD_RTS_OFF    4'h9
`define UCD_CMD_TMO_ON     4'hA
`define UCD_CMD_MRP_ZERO   4'hB
`define UCD_CMD_TMO_OFF    4'hC
`define UCD_CMD_UNUSED     4'hD
`define UCD_CMD_PD_ON      4'hE
`define UCD_CMD_PD_OFF     4'hF
`define UCD_MRP_ZERO_VAL   2'h0
`define UCD_BIT_DIV_DEF    16'd16
`endif

// File: src/ucd_pkg.sv
// types shared by the channel command decoder
// no assumptions beyond the register header
package ucd_pkg;
  typedef enum logic [1:0] {
    UCD_BRK_IDLE,
    UCD_BRK_WAIT,
    UCD_BRK_SPACE,
    UCD_BRK_MARK
  } ucd_brk_t;
endpackage : ucd_pkg

// File: src/ucd_decoder.sv
// miscellaneous command decoder for two serial channels, avalon-mm register slave
// assumes the transmitter core reports busy/queued state and a bit-time tick per channel
`timescale 1ns/10ps
`include "ucd_regs.svh"
module ucd_decoder
  import ucd_pkg::*;
#(
  parameter int NCH = 2
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [1:0]  tx_busy,
  input  wire logic [1:0]  tx_queued,
  input  wire logic [1:0]  tx_data_in,
  input  wire logic [1:0]  bit_tick,
  input  wire logic [1:0]  rx_char_loaded,
  output logic [1:0]       serial_tx_out,
  output logic [1:0]       request_to_send_out_low,
  output logic [1:0]       tx_enabled,
  output logic [1:0]       rx_enabled,
  output logic [1:0]       tx_hold,
  output logic [1:0]       mode_register_pointer_clr,
  output logic             ct_restart,
  output logic             ct_stop,
  output logic             ct_counter_mode,
  output logic             ct_cmds_blocked,
  output logic             ct_ready_clr,
  output logic             osc_enable
);

  // one-cycle answer: waitrequest drops in the cycle after a request rises
  logic       ack_r;
  logic       wr_a;
  logic       wr_b;
  logic [3:0] code_a;
  logic [3:0] code_b;
  logic [1:0] wr_ch;
  logic [3:0] code_ch [2];
  logic       pd_r;
  logic       tmo_r;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign code_a = avs_writedata[`UCD_CODE_MSB:`UCD_CODE_LSB];
  assign code_b = avs_writedata[`UCD_CODE_MSB:`UCD_CODE_LSB];
  // a write lands at the edge where the master sees waitrequest low, never earlier
  logic acc_wr;
  assign acc_wr = avs_write & ack_r;
  assign wr_a = acc_wr & (avs_address == `UCD_OFS_CMD_A);
  assign wr_b = acc_wr & (avs_address == `UCD_OFS_CMD_B);
  // while powered down only code F is honoured on channel a, nothing on b
  assign wr_ch[0] = wr_a & (~pd_r | (code_a == `UCD_CMD_PD_OFF));
  assign wr_ch[1] = wr_b & ~pd_r;
  assign code_ch[0] = code_a;
  assign code_ch[1] = code_b;

  // bus handshake register; every request sees exactly one wait state
  // so a write acts only at the edge the master takes as the answer
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  // power-down state; the oscillator gate is the clock-enable for the channels
  // exit is decoded from the raw strobe so it works while the channels are frozen
  always_ff @(posedge clk) begin
    if (rst) begin
      pd_r <= 1'b0;
    end else if (wr_a && code_a == `UCD_CMD_PD_ON && !pd_r) begin
      pd_r <= 1'b1;
    end else if (wr_a && code_a == `UCD_CMD_PD_OFF) begin
      pd_r <= 1'b0;
    end
  end
  assign osc_enable = ~pd_r;

  // time-out mode, shared counter/timer steering from channel a or b
  // time-out steering decoded per channel
  logic       tmo_on_any;
  logic       tmo_off_any;
  logic [1:0] tmo_on_ch;
  logic [1:0] tmo_off_ch;
  logic [1:0] tmo_ch_r;
  assign tmo_on_ch[0]  = wr_ch[0] && code_ch[0] == `UCD_CMD_TMO_ON;
  assign tmo_on_ch[1]  = wr_ch[1] && code_ch[1] == `UCD_CMD_TMO_ON;
  assign tmo_off_ch[0] = wr_ch[0] && code_ch[0] == `UCD_CMD_TMO_OFF;
  assign tmo_off_ch[1] = wr_ch[1] && code_ch[1] == `UCD_CMD_TMO_OFF;
  // one shared timer: entry from either channel wins over an exit in the same cycle
  assign tmo_on_any    = |tmo_on_ch;
  assign tmo_off_any   = |tmo_off_ch;

  always_ff @(posedge clk) begin
    if (rst) begin
      tmo_r    <= 1'b0;
      tmo_ch_r <= 2'h0;
    end else if (tmo_on_any) begin
      tmo_r    <= 1'b1;
      tmo_ch_r <= tmo_on_ch;
    end else if (tmo_off_any) begin
      tmo_r    <= 1'b0; // counter left running, nothing cleared
      tmo_ch_r <= 2'h0;
    end
  end

  // timer pulses; restart frozen in power-down since clocked functions halt
  // pulses are registered, so the timer sees them one cycle after the write edge
  always_ff @(posedge clk) begin
    if (rst) begin
      ct_restart   <= 1'b0;
      ct_stop      <= 1'b0;
      ct_ready_clr <= 1'b0;
    end else begin
      ct_restart   <= tmo_r & ~pd_r & |(rx_char_loaded & tmo_ch_r);
      ct_stop      <= tmo_on_any;
      ct_ready_clr <= tmo_on_any;
    end
  end
  assign ct_counter_mode = tmo_r;
  assign ct_cmds_blocked = tmo_r;

  logic [1:0] cmd_ack_rd;
  // per-channel logic
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      logic       wr;
      logic [3:0] cd;
      logic [3:0] low;
      ucd_brk_t   brk_r;
      logic [1:0] tick_cnt_r;
      logic       tx_en_r;
      logic       rx_en_r;
      logic       rts_low_r;
      logic       mrp_r;
      logic       tick;
      logic       tx_en_nxt;
      logic       rx_en_nxt;
      logic       tx_line_nxt;
      logic       do_start_brk;
      logic       do_stop_brk;
      logic       do_rts_on;
      logic       do_rts_off;
      logic       do_mrp_zero;

      assign wr   = wr_ch[gi];
      assign cd   = code_ch[gi];
      assign low  = avs_writedata[3:0];
      assign tick = bit_tick[gi] & ~pd_r; // no bit time passes while stopped

      // one strobe per code, so the rts, pointer and break processes below read named events, not raw codes
      assign do_start_brk = wr && cd == `UCD_CMD_START_BRK;
      assign do_stop_brk  = wr && cd == `UCD_CMD_STOP_BRK;
      assign do_rts_on    = wr && cd == `UCD_CMD_RTS_ON;
      assign do_rts_off   = wr && cd == `UCD_CMD_RTS_OFF;
      assign do_mrp_zero  = wr && cd == `UCD_CMD_MRP_ZERO;

      // enable bits; disable wins if both are set, the safer reading of a conflicting word
      always_comb begin
        tx_en_nxt = tx_en_r;
        rx_en_nxt = rx_en_r;
        if (wr) begin
          if (low[`UCD_BIT_TX_DIS]) begin
            tx_en_nxt = 1'b0;
          end else if (low[`UCD_BIT_TX_EN]) begin
            tx_en_nxt = 1'b1;
          end
          if (low[`UCD_BIT_RX_DIS]) begin
            rx_en_nxt = 1'b0;
          end else if (low[`UCD_BIT_RX_EN]) begin
            rx_en_nxt = 1'b1;
          end
        end
      end

      // enable registers
      always_ff @(posedge clk) begin
        if (rst) begin
          tx_en_r <= 1'b0;
          rx_en_r <= 1'b0;
        end else begin
          tx_en_r <= tx_en_nxt;
          rx_en_r <= rx_en_nxt;
        end
      end

      // request-to-send, active low, deasserted after reset
      // a plain level: the far end must not be asked to send before software says so
      always_ff @(posedge clk) begin
        if (rst) begin
          rts_low_r <= 1'b1;
        end else if (do_rts_on) begin
          rts_low_r <= 1'b0;
        end else if (do_rts_off) begin
          rts_low_r <= 1'b1;
        end
      end

      // mode pointer reset pulse
      // a pulse only: the pointer itself lives with the mode registers outside
      always_ff @(posedge clk) begin
        if (rst) begin
          mrp_r <= 1'b0;
        end else begin
          mrp_r <= do_mrp_zero;
        end
      end

      // break sequencer: wait drains the transmitter, then space, then one marking bit
      always_ff @(posedge clk) begin
        if (rst) begin
          brk_r      <= UCD_BRK_IDLE;
          tick_cnt_r <= 2'h0;
        end else begin
          case (brk_r)
            UCD_BRK_IDLE: begin
              if (do_start_brk && tx_en_r) begin
                brk_r      <= UCD_BRK_WAIT;
                tick_cnt_r <= 2'h0;
              end
            end
            UCD_BRK_WAIT: begin
              if (do_stop_brk) begin
                brk_r <= UCD_BRK_IDLE;
              end else if (!tx_busy[gi] && !tx_queued[gi] && tick) begin
                brk_r <= UCD_BRK_SPACE; // starts at next bit tick, within two bits
              end
            end
            UCD_BRK_SPACE: begin
              if (do_stop_brk) begin
                brk_r      <= UCD_BRK_MARK; // marking at once, well inside two bits
                tick_cnt_r <= 2'h0;
              end
            end
            UCD_BRK_MARK: begin
              // two ticks guarantee a full bit of marking whatever the tick phase
              if (tick) begin
                tick_cnt_r <= tick_cnt_r + 2'h1;
                if (tick_cnt_r == 2'h1) begin
                  brk_r <= UCD_BRK_IDLE; // one full bit time marking
                end
              end
            end
            default: brk_r <= UCD_BRK_IDLE;
          endcase
        end
      end

      // line level chosen by the break state, otherwise the core's own bit
      always_comb begin
        tx_line_nxt = tx_data_in[gi];
        case (brk_r)
          UCD_BRK_SPACE: tx_line_nxt = 1'b0;
          UCD_BRK_MARK:  tx_line_nxt = 1'b1;
          default:       tx_line_nxt = tx_data_in[gi];
        endcase
      end

      // transmit output register; held through power-down so the line keeps its level
      always_ff @(posedge clk) begin
        if (rst) begin
          serial_tx_out[gi] <= 1'b1;
        end else if (!pd_r) begin
          serial_tx_out[gi] <= tx_line_nxt;
        end
      end

      assign request_to_send_out_low[gi]   = rts_low_r;
      assign tx_enabled[gi]                = tx_en_r;
      assign rx_enabled[gi]                = rx_en_r;
      // transmitter core must not load a new character while the break runs
      assign tx_hold[gi]                   = (brk_r == UCD_BRK_SPACE) || (brk_r == UCD_BRK_MARK);
      assign mode_register_pointer_clr[gi] = mrp_r;
      assign cmd_ack_rd[gi]                = (brk_r != UCD_BRK_IDLE);
    end
  endgenerate

  // status word, assembled field by field so the layout is easy to audit
  logic [31:0] status_word;
  logic [31:0] brk_word;
  always_comb begin
    status_word        = 32'h0;
    status_word[1:0]   = request_to_send_out_low;
    status_word[3:2]   = tx_enabled;
    status_word[5:4]   = rx_enabled;
    status_word[6]     = pd_r;
    status_word[7]     = tmo_r;
    status_word[9:8]   = tmo_ch_r;
    status_word[11:10] = cmd_ack_rd;
  end

  // break state of both channels, a debug view only
  always_comb begin
    brk_word      = 32'h0;
    brk_word[1:0] = g_ch[0].brk_r;
    brk_word[3:2] = g_ch[1].brk_r;
  end

  // read data; code D writes act only through the enable bits, unmapped writes have no side effect, reads return zero
  // reads are registered in the first cycle and stand at the answering edge
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !ack_r) begin
      case (avs_address)
        `UCD_OFS_STATUS: avs_readdata <= status_word;
        `UCD_OFS_EVENT:  avs_readdata <= brk_word;
        default:         avs_readdata <= 32'h0;
      endcase
    end
  end

endmodule : ucd_decoder

// File: bench/ucd_chk.sv
// port assertions for the channel command decoder
// bound onto ucd_decoder, one clock, sync reset
`timescale 1ns/10ps
module ucd_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  rx_char_loaded,
  input wire logic [1:0]  request_to_send_out_low,
  input wire logic [1:0]  tx_enabled,
  input wire logic [1:0]  tx_hold,
  input wire logic [1:0]  mode_register_pointer_clr,
  input wire logic        ct_restart,
  input wire logic        ct_stop,
  input wire logic        ct_counter_mode,
  input wire logic        ct_cmds_blocked,
  input wire logic        ct_ready_clr,
  input wire logic        osc_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // accepted write while clocked; pd writes judged elsewhere
  wire       acc = avs_write && !avs_waitrequest && osc_enable;
  wire [3:0] cd  = avs_writedata[7:4];
  wire       cha = acc && avs_address == 4'h0;
  wire       chb = acc && avs_address == 4'h4;
  chk_wait_first: assert property ($rose(avs_write) |-> avs_waitrequest)
    else $error("write taken without wait cycle");
  chk_wait_one: assert property (avs_write && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait longer than one cycle");
  chk_rts_on: assert property (cha && cd == 4'h8 |=> !request_to_send_out_low[0])
    else $error("rts a not asserted");
  chk_rts_off_b: assert property (chb && cd == 4'h9 |=> request_to_send_out_low[1])
    else $error("rts b not negated");
  chk_mrp_zero: assert property (chb && cd == 4'hB |=> mode_register_pointer_clr[1])
    else $error("pointer clear missing");
  chk_tmo_entry: assert property (cha && cd == 4'hA |-> ##[1:2] ct_stop && ct_ready_clr && ct_cmds_blocked)
    else $error("time-out entry incomplete");
  chk_tmo_exit: assert property (cha && cd == 4'hC |=> (!ct_stop && !ct_ready_clr)[*2] ##0 !ct_cmds_blocked)
    else $error("time-out exit wrong");
  chk_tmo_restart: assert property (ct_counter_mode && rx_char_loaded[0] && osc_enable |-> ##[1:2] ct_restart)
    else $error("timer not restarted");
  chk_pd_b_none: assert property (chb && cd == 4'hE |=> osc_enable)
    else $error("power-down taken on b");
  chk_brk_refused: assert property (cha && cd == 4'h6 && !tx_enabled[0] && !avs_writedata[2] |=> (!tx_hold[0])[*3])
    else $error("break taken while disabled");
  chk_pd_hold: assert property (!osc_enable && !$past(osc_enable) |-> $stable(request_to_send_out_low))
    else $error("state moved in power-down");
  cov_pd: cover property (!osc_enable);
  cov_brk: cover property (tx_hold[0]);
  cov_tmo: cover property (ct_restart);
endmodule : ucd_chk
bind ucd_decoder ucd_chk ucd_chk_i (.*);

// File: bench/ucd_tick_model.sv
// far-side baud timing: one tick per bit time per channel
// assumes one clock, sync active-high reset
`timescale 1ns/10ps
module ucd_tick_model #(
  parameter int BT = 4
) (
  input  wire logic  clk,
  input  wire logic  rst,
  output logic [1:0] bit_tick
);
  int cnt_r;
  // free-running divider; short bit time keeps the run brief
  always_ff @(posedge clk) begin
    cnt_r    <= (rst || cnt_r == BT - 1) ? 0 : cnt_r + 1;
    bit_tick <= {2{!rst && cnt_r == BT - 1}};
  end
endmodule : ucd_tick_model

// File: bench/tb.sv
// self-checking bench for the channel command decoder
// assumes ucd_decoder, ucd_tick_model, 100 ns clock
`timescale 1ns/10ps
module tb;
  localparam int BT = 4;
  logic        clk, rst, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdat;
  logic        ct_restart, ct_stop, ct_counter_mode, ct_cmds_blocked, ct_ready_clr, osc_enable;
  logic [1:0]  tx_busy, tx_queued, bit_tick, rx_char_loaded, serial_tx_out, request_to_send_out_low;
  logic [1:0]  tx_enabled, rx_enabled, tx_hold, mode_register_pointer_clr;
  logic [1:0]  tx_data_in = 2'b11;
  int          err_count, cmp_count;
  ucd_decoder ucd_decoder_i (.*);
  ucd_tick_model #(.BT(BT)) ucd_tick_model_i (.*);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // one bus cycle, held to the edge that sees waitrequest low, then idle edges
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, d};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    {avs_write, avs_read} <= 2'b00;
    repeat (2) @(negedge clk);
  endtask : bus
  task automatic wtx(input logic v, input int n);
    for (int i = 0; i < n && serial_tx_out[0] !== v; i++) @(negedge clk);
  endtask : wtx
  task automatic t_rts;
    chk(request_to_send_out_low, 2'b11);
    bus(1'b1, 4'h0, 32'h80);
    chk(request_to_send_out_low, 2'b10);
    bus(1'b1, 4'h4, 32'h85); // rts on with tx and rx enable in one word
    chk(request_to_send_out_low, 2'b00);
    chk({rx_enabled, tx_enabled}, 4'b1010);
    bus(1'b1, 4'h0, 32'h90);
    chk(request_to_send_out_low, 2'b01);
    bus(1'b1, 4'h0, 32'hD0);
    chk(request_to_send_out_low, 2'b01);
    bus(1'b0, 4'h8, 32'h0);
    chk(rdat[1:0], 2'b01);
    bus(1'b0, 4'h2, 32'h0);
    chk(rdat, 32'h0);
  endtask : t_rts
  task automatic t_tmo;
    bus(1'b1, 4'h0, 32'hA0);
    chk({ct_counter_mode, ct_cmds_blocked}, 2'b11);
    @(posedge clk);
    rx_char_loaded <= 2'b01;
    @(posedge clk);
    rx_char_loaded <= 2'b00;
    @(negedge clk);
    chk(ct_restart, 1'b1);
    bus(1'b1, 4'h4, 32'hB0);
    bus(1'b1, 4'h0, 32'hC0); // stop-counter lives in the timer, not here
    chk(ct_cmds_blocked, 1'b0);
  endtask : t_tmo
  // break held off by a busy, queued transmitter, then released
  task automatic t_brk;
    bus(1'b1, 4'h0, 32'h60);
    chk(tx_hold[0], 1'b0);
    @(posedge clk);
    {tx_busy, tx_queued} <= 4'b0101;
    bus(1'b1, 4'h0, 32'h04);
    bus(1'b1, 4'h0, 32'h60);
    repeat (3 * BT) @(negedge clk);
    chk(serial_tx_out[0], 1'b1);
    @(posedge clk);
    {tx_busy, tx_queued} <= 4'b0000;
    wtx(1'b0, 2 * BT + 2);
    chk(serial_tx_out[0], 1'b0);
    bus(1'b1, 4'h0, 32'h70);
    wtx(1'b1, 2 * BT - 2);
    chk(serial_tx_out[0], 1'b1);
    chk(tx_hold[0], 1'b1);
  endtask : t_brk
  task automatic t_pd;
    bus(1'b1, 4'h4, 32'hE0);
    chk(osc_enable, 1'b1);
    bus(1'b1, 4'h0, 32'h0A);
    bus(1'b1, 4'h4, 32'h0A);
    bus(1'b1, 4'h0, 32'hE0);
    chk(osc_enable, 1'b0);
    repeat (4 * BT) @(negedge clk);
    chk({request_to_send_out_low, tx_enabled}, 4'b0100);
    bus(1'b1, 4'h0, 32'hF0); // only the exit code while powered down
    chk(osc_enable, 1'b1);
    repeat (BT) @(negedge clk); // oscillator start-up wait
    bus(1'b1, 4'h0, 32'h80);
    chk(request_to_send_out_low, 2'b00);
  endtask : t_pd
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results
  initial begin
    {avs_read, avs_write, tx_busy, tx_queued, rx_char_loaded} = '0;
    {avs_address, avs_writedata, err_count, cmp_count} = '0;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_rts;
    t_tmo;
    t_brk;
    t_pd;
    results;
  end
  // hang guard, far beyond the hundred-odd cycles expected
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    results;
  end
endmodule : tb
